// ==== core/hsr_pkg.sv ====
package hsr_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 15;
    localparam int RW_BIT = 15;
    localparam logic CMD_READ = 1'h1;
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'hF;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [14:0] ADDR_ZERO = 15'h0000;
    localparam logic [14:0] ADDR_ONE = 15'h0001;
    localparam int ARR_AW = 5;
    localparam int ARR_DEPTH = 32;
    localparam int MCLK_PERIOD_PS = 100000;
    localparam int LINK_MIN_PERIOD_PS = 62500;
    localparam int SYNC_STAGES = 2;
    localparam int HALF_MIN_CYC = (LINK_MIN_PERIOD_PS / 2 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
    localparam int HALF_CYC = (HALF_MIN_CYC > SYNC_STAGES) ? HALF_MIN_CYC : SYNC_STAGES;
    localparam logic [1:0] HALF_LAST = 2'(HALF_CYC - 1);
    localparam logic [1:0] DIV_ZERO = 2'h0;
    localparam logic [1:0] DIV_ONE = 2'h1;
    typedef logic [WORD_W-1:0] hsr_word_t;
    typedef logic [ADDR_W-1:0] hsr_addr_t;
    typedef enum logic [2:0] {
        D_INSTR = 3'h0,
        D_COUNT = 3'h1,
        D_READ = 3'h2,
        D_WRITE = 3'h3,
        D_DONE = 3'h4
    } hsr_dev_st_t;
    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_SETUP = 2'h1,
        H_SHIFT = 2'h2,
        H_HOLD = 2'h3
    } hsr_host_st_t;
endpackage

// ==== core/hsr_link_if.sv ====
interface hsr_link_if;
    logic sclk;
    logic cs_n;
    logic host_sdio_o;
    logic host_sdio_oe;
    logic dev_sdio_o;
    logic dev_sdio_oe;
    logic sdio;
    logic serial_out_line;

    // The shared data wire reads low when nobody drives it, like a weak pull-down.
    assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b0);

    modport host (
        output sclk,
        output cs_n,
        output host_sdio_o,
        output host_sdio_oe,
        input sdio,
        input serial_out_line
    );
    modport dev (
        input sclk,
        input cs_n,
        input sdio,
        output dev_sdio_o,
        output dev_sdio_oe,
        output serial_out_line
    );
endinterface

// ==== core/hsr_sync2.sv ====
module hsr_sync2 #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;

    // No reset: the chain flushes itself within two edges.
    always_ff @(posedge i_clk) begin
        meta_r <= i_d;
        o_q <= meta_r;
    end
endmodule

// ==== core/hsr_dev_end.sv ====
module hsr_dev_end (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_three_wire,
    input wire logic i_lsb_first,
    input wire logic i_addr_dec,
    output logic o_sel_active,
    output logic o_acc_valid,
    output logic o_acc_wr,
    output hsr_pkg::hsr_addr_t o_acc_addr,
    output hsr_pkg::hsr_word_t o_acc_data,
    hsr_link_if.dev link
);
    import hsr_pkg::*;

    // Link side: everything below up to the crossing runs on the shift clock.
    logic [2:0] cfg_s;
    wire three_wire = cfg_s[2];
    wire lsb_first = cfg_s[1];
    wire addr_dec = cfg_s[0];

    // Mode straps are slow levels; they must be stable two shift edges before a frame uses them.
    hsr_sync2 #(
        .W(3)
    ) u_cfg_sync (
        .i_clk(link.sclk),
        .i_d({i_three_wire, i_lsb_first, i_addr_dec}),
        .o_q(cfg_s)
    );

    hsr_dev_st_t st_r;
    hsr_dev_st_t st_nxt;
    logic [3:0] bit_r;
    hsr_word_t sh_r;
    hsr_addr_t addr_r;
    hsr_addr_t addr_nxt;
    hsr_word_t left_r;
    hsr_word_t left_nxt;
    hsr_word_t mem [ARR_DEPTH];
    logic out_r;
    logic oe_r;
    logic ev_tgl_r;
    logic ev_wr_q;
    hsr_addr_t ev_addr_q;
    hsr_word_t ev_data_q;

    wire sdi = link.sdio;
    wire word_end = (bit_r == BIT_LAST);
    wire [WORD_W-1:0] sh_nxt = lsb_first ? {sdi, sh_r[WORD_W-1:1]} : {sh_r[WORD_W-2:0], sdi};
    wire cnt_small = (sh_nxt == WORD_ZERO) || (sh_nxt == CNT_ONE);
    wire [WORD_W-1:0] rd_count = cnt_small ? CNT_ONE : sh_nxt;
    wire [ADDR_W-1:0] addr_step = addr_dec ? (addr_r - ADDR_ONE) : (addr_r + ADDR_ONE);
    wire [WORD_W-1:0] rd_word = mem[addr_r[ARR_AW-1:0]];
    wire [3:0] rd_idx = lsb_first ? bit_r : ~bit_r;

    // Only a completed word ever reaches the array, so a frame cut short stores nothing partial.
    wire mem_we = word_end && (st_r == D_WRITE);
    wire rd_fetch = word_end && ((st_r == D_COUNT) || ((st_r == D_READ) && (left_r != CNT_ONE)));
    wire ev_take = mem_we || rd_fetch;

    always_comb begin
        st_nxt = st_r;
        addr_nxt = addr_r;
        left_nxt = left_r;
        if (word_end) begin
            unique case (st_r)
                D_INSTR: begin
                    addr_nxt = sh_nxt[ADDR_W-1:0];
                    st_nxt = (sh_nxt[RW_BIT] == CMD_READ) ? D_COUNT : D_WRITE;
                end
                D_COUNT: begin
                    left_nxt = rd_count;
                    st_nxt = D_READ;
                end
                D_READ: begin
                    addr_nxt = addr_step;
                    left_nxt = left_r - CNT_ONE;
                    st_nxt = (left_r == CNT_ONE) ? D_DONE : D_READ;
                end
                D_WRITE: begin
                    addr_nxt = addr_step;
                end
                D_DONE: begin
                    st_nxt = D_DONE;
                end
                default: begin
                    st_nxt = D_DONE;
                end
            endcase
        end
    end

    // Select high is the frame reset; a falling select thus always meets fresh counters.
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            st_r <= D_INSTR;
            bit_r <= BIT_FIRST;
            sh_r <= WORD_ZERO;
            addr_r <= ADDR_ZERO;
            left_r <= WORD_ZERO;
        end else begin
            st_r <= st_nxt;
            bit_r <= bit_r + 4'h1;
            sh_r <= sh_nxt;
            addr_r <= addr_nxt;
            left_r <= left_nxt;
        end
    end

    // The array only exists to hold written words; it has no reset by design.
    always_ff @(posedge link.sclk) begin
        if (mem_we) begin
            mem[addr_r[ARR_AW-1:0]] <= sh_nxt;
        end
    end

    // Output changes on the falling edge; the host samples the synchronised bit when it next drops the clock.
    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            out_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            out_r <= rd_word[rd_idx];
            oe_r <= (st_r == D_READ);
        end
    end

    assign link.serial_out_line = (!three_wire && oe_r) ? out_r : 1'b0;
    assign link.dev_sdio_o = out_r;
    assign link.dev_sdio_oe = three_wire && oe_r;

    // The event toggle must survive frame ends, so it is cleared by the system reset only.
    always_ff @(posedge link.sclk or negedge i_nrst) begin
        if (!i_nrst) begin
            ev_tgl_r <= 1'b0;
            ev_wr_q <= 1'b0;
            ev_addr_q <= ADDR_ZERO;
            ev_data_q <= WORD_ZERO;
        end else if (ev_take) begin
            ev_tgl_r <= ~ev_tgl_r;
            ev_wr_q <= mem_we;
            ev_addr_q <= mem_we ? addr_r : addr_nxt;
            ev_data_q <= mem_we ? sh_nxt : mem[addr_nxt[ARR_AW-1:0]];
        end
    end

    // System side: words at least sixteen shift clocks apart leave plenty of time for the toggle.
    logic [1:0] lvl_s;
    logic ev_seen_r;

    hsr_sync2 #(
        .W(2)
    ) u_evt_sync (
        .i_clk(i_mclk),
        .i_d({ev_tgl_r, link.cs_n}),
        .o_q(lvl_s)
    );

    wire ev_new = (lvl_s[1] != ev_seen_r);

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            ev_seen_r <= 1'b0;
            o_acc_valid <= 1'b0;
            o_acc_wr <= 1'b0;
            o_acc_addr <= ADDR_ZERO;
            o_acc_data <= WORD_ZERO;
            o_sel_active <= 1'b0;
        end else begin
            ev_seen_r <= lvl_s[1];
            o_acc_valid <= ev_new;
            o_sel_active <= ~lvl_s[0];
            if (ev_new) begin
                o_acc_wr <= ev_wr_q;
                o_acc_addr <= ev_addr_q;
                o_acc_data <= ev_data_q;
            end
        end
    end
endmodule

// ==== core/hsr_host_end.sv ====
module hsr_host_end (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_three_wire,
    input wire logic i_lsb_first,
    input wire logic i_start,
    input wire logic i_rw,
    input wire hsr_pkg::hsr_addr_t i_addr,
    input wire hsr_pkg::hsr_word_t i_count,
    input wire hsr_pkg::hsr_word_t i_wdata,
    input wire logic i_wvalid,
    output logic o_wready,
    output hsr_pkg::hsr_word_t o_rdata,
    output logic o_rvalid,
    output logic o_busy,
    output logic o_done,
    hsr_link_if.host link
);
    import hsr_pkg::*;

    hsr_host_st_t st_r;
    logic [1:0] div_r;
    logic sclk_r;
    logic cs_n_r;
    logic [3:0] bit_r;
    logic rw_r;
    logic ph_instr_r;
    logic ph_cnt_r;
    hsr_word_t cnt_r;
    hsr_word_t left_r;
    hsr_word_t tx_r;
    hsr_word_t rx_r;
    logic [1:0] din_s;

    // Device data crosses from the shift clock domain; a half period of two cycles covers the delay.
    hsr_sync2 #(
        .W(2)
    ) u_din_sync (
        .i_clk(i_mclk),
        .i_d({link.sdio, link.serial_out_line}),
        .o_q(din_s)
    );

    wire sdi_s = i_three_wire ? din_s[1] : din_s[0];
    wire word_end = (bit_r == BIT_LAST);
    wire last_data = !ph_instr_r && !ph_cnt_r && (left_r == CNT_ONE);
    wire need_wd = word_end && sclk_r && !rw_r && !ph_cnt_r && !last_data;
    wire stall = need_wd && !i_wvalid;
    wire tick = (div_r == HALF_LAST) && !stall;
    wire fall = (st_r == H_SHIFT) && tick && sclk_r;
    wire [WORD_W-1:0] rx_nxt = i_lsb_first ? {sdi_s, rx_r[WORD_W-1:1]} : {rx_r[WORD_W-2:0], sdi_s};
    wire [WORD_W-1:0] tx_sh = i_lsb_first ? {1'b0, tx_r[WORD_W-1:1]} : {tx_r[WORD_W-2:0], 1'b0};
    wire [WORD_W-1:0] count_one = (i_count == WORD_ZERO) ? CNT_ONE : i_count;
    wire read_phase = rw_r && !ph_instr_r && !ph_cnt_r;

    assign o_wready = (st_r == H_SHIFT) && (div_r == HALF_LAST) && need_wd && i_wvalid;
    assign o_busy = (st_r != H_IDLE);
    assign link.sclk = sclk_r;
    assign link.cs_n = cs_n_r;
    assign link.host_sdio_o = i_lsb_first ? tx_r[0] : tx_r[WORD_W-1];
    // In three-wire reads the line is released before the device starts driving it.
    assign link.host_sdio_oe = !cs_n_r && !(i_three_wire && read_phase);

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            st_r <= H_IDLE;
            div_r <= DIV_ZERO;
            sclk_r <= 1'b0;
            cs_n_r <= 1'b1;
            bit_r <= BIT_FIRST;
            rw_r <= 1'b0;
            ph_instr_r <= 1'b0;
            ph_cnt_r <= 1'b0;
            cnt_r <= WORD_ZERO;
            left_r <= WORD_ZERO;
            tx_r <= WORD_ZERO;
            rx_r <= WORD_ZERO;
            o_rdata <= WORD_ZERO;
            o_rvalid <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_rvalid <= 1'b0;
            o_done <= 1'b0;
            if (st_r != H_IDLE) begin
                div_r <= tick ? DIV_ZERO : (stall ? div_r : div_r + DIV_ONE);
            end
            unique case (st_r)
                H_IDLE: begin
                    if (i_start) begin
                        st_r <= H_SETUP;
                        div_r <= DIV_ZERO;
                        cs_n_r <= 1'b0;
                        bit_r <= BIT_FIRST;
                        rw_r <= i_rw;
                        ph_instr_r <= 1'b1;
                        ph_cnt_r <= 1'b0;
                        cnt_r <= i_count;
                        left_r <= count_one;
                        tx_r <= {i_rw, i_addr};
                    end
                end
                H_SETUP: begin
                    if (tick) begin
                        st_r <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (tick && !sclk_r) begin
                        sclk_r <= 1'b1;
                    end
                    if (fall) begin
                        sclk_r <= 1'b0;
                        rx_r <= rx_nxt;
                        bit_r <= bit_r + 4'h1;
                        tx_r <= tx_sh;
                        if (word_end) begin
                            ph_instr_r <= 1'b0;
                            ph_cnt_r <= ph_instr_r && rw_r;
                            if (ph_instr_r && rw_r) begin
                                tx_r <= cnt_r;
                            end else if (need_wd) begin
                                tx_r <= i_wdata;
                            end
                            if (!ph_instr_r && !ph_cnt_r) begin
                                left_r <= left_r - CNT_ONE;
                                o_rvalid <= rw_r;
                                o_rdata <= rw_r ? rx_nxt : o_rdata;
                            end
                            // Select stays low until the final requested word has been shifted.
                            if (last_data) begin
                                st_r <= H_HOLD;
                            end
                        end
                    end
                end
                H_HOLD: begin
                    if (tick) begin
                        st_r <= H_IDLE;
                        cs_n_r <= 1'b1;
                        o_done <= 1'b1;
                    end
                end
            endcase
        end
    end
endmodule

// ==== testbench/hsr_link_props.sv ====
module hsr_link_props (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic host_sdio_o,
    input wire logic host_sdio_oe,
    input wire logic dev_sdio_o,
    input wire logic dev_sdio_oe,
    input wire logic serial_out_line
);
    logic sclk_d_r;
    logic [15:0] rise_cnt_r;
    logic [15:0] rise_cnt_nxt;
    // The shift clock is a register of the system clock, so its rises can be counted here exactly.
    assign rise_cnt_nxt = (sclk && !sclk_d_r) ? rise_cnt_r + 16'h0001 : rise_cnt_r;
    always_ff @(posedge i_mclk) begin
        sclk_d_r <= sclk;
        if (!i_nrst || cs_n) begin
            rise_cnt_r <= 16'h0000;
        end else begin
            rise_cnt_r <= rise_cnt_nxt;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    sequence s_sel_fall;
        $fell(cs_n);
    endsequence
    sequence s_first_rise;
        !sclk ##[1:8] sclk;
    endsequence
    property p_setup;
        s_sel_fall |-> s_first_rise;
    endproperty
    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("Shift clock high while deselected");
    a_dev_idle_quiet: assert property (cs_n |-> !dev_sdio_oe && !serial_out_line)
        else $error("Device drives data while deselected");
    a_no_contention: assert property (dev_sdio_oe |-> !host_sdio_oe)
        else $error("Both ends drive the shared data line");
    a_setup_before_clk: assert property (p_setup)
        else $error("No shift clock soon after select fell");
    a_hold_before_rise: assert property ($rose(cs_n) |-> !$past(sclk, 1) && !$past(sclk, 2))
        else $error("Select released too close to a clock edge");
    a_host_data_stable: assert property (sclk && host_sdio_oe |-> $stable(host_sdio_o))
        else $error("Host data moved while shift clock high");
    a_shift_on_fall: assert property (!cs_n && !$past(cs_n) && $changed(serial_out_line) |-> $fell(sclk))
        else $error("Device output changed off a falling edge");
    a_enable_on_fall: assert property (!cs_n && !$past(cs_n) && $changed(dev_sdio_oe) |-> $fell(sclk))
        else $error("Device enable changed off a falling edge");
    a_whole_words: assert property ($rose(cs_n) |-> rise_cnt_r[3:0] == 4'h0 && rise_cnt_r >= 16'h0020)
        else $error("Frame did not end on a whole word");
    a_read_data_late: assert property (dev_sdio_oe || serial_out_line |-> rise_cnt_r >= 16'h0020)
        else $error("Device drove data before clock 33");
endmodule

// ==== testbench/tb_top.sv ====
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import hsr_pkg::*;
    logic i_mclk, i_nrst, i_three_wire, i_lsb_first, i_addr_dec, i_start, i_rw, i_wvalid;
    logic o_wready, o_rvalid, o_done, o_acc_valid, o_acc_wr, o_sel_active, o_busy;
    hsr_addr_t i_addr, o_acc_addr;
    hsr_word_t i_count, i_wdata, o_rdata, o_acc_data, instr;
    hsr_word_t wq[$];
    hsr_word_t rq[$];
    logic [31:0] ev[$];
    int err_total = 0;
    int comparisons = 0;
    int nb = 0;
    hsr_link_if link();
    hsr_host_end u_hsr_host_end (.i_mclk, .i_nrst, .i_three_wire, .i_lsb_first, .i_start, .i_rw, .i_addr,
        .i_count, .i_wdata, .i_wvalid, .o_wready, .o_rdata, .o_rvalid, .o_busy, .o_done, .link(link));
    hsr_dev_end u_hsr_dev_end (.i_mclk, .i_nrst, .i_three_wire, .i_lsb_first, .i_addr_dec, .o_sel_active,
        .o_acc_valid, .o_acc_wr, .o_acc_addr, .o_acc_data, .link(link));
    hsr_link_props u_hsr_link_props (.i_mclk, .i_nrst, .sclk(link.sclk), .cs_n(link.cs_n),
        .host_sdio_o(link.host_sdio_o), .host_sdio_oe(link.host_sdio_oe), .dev_sdio_o(link.dev_sdio_o),
        .dev_sdio_oe(link.dev_sdio_oe), .serial_out_line(link.serial_out_line));
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    always @(negedge link.cs_n) nb = 0;
    always @(posedge link.sclk) begin
        if (link.cs_n === 1'b0) begin
            if (nb < 16) instr = {instr[14:0], link.sdio};
            nb++;
        end
    end
    // Events are taken mid-cycle so the pulse is never read in the step that launches it.
    always @(negedge i_mclk) begin
        if (o_acc_valid === 1'b1) ev.push_back({o_acc_wr, o_acc_addr, o_acc_data});
    end
    task automatic wrap_up();
        if (err_total == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Write data is streamed one word per accepted handshake; one-cycle pulses are read mid-cycle.
    task automatic frame(input logic rw, input hsr_addr_t a, input hsr_word_t n);
        int k;
        logic wr;
        logic dn;
        logic sa;
        logic bz;
        k = 0;
        dn = 1'b0;
        sa = 1'b0;
        bz = 1'b0;
        rq = {};
        i_rw = rw;
        i_addr = a;
        i_count = n;
        i_wdata = (wq.size() > 0) ? wq[0] : WORD_ZERO;
        i_wvalid = !rw;
        i_start = 1'b1;
        @(posedge i_mclk);
        #1 i_start = 1'b0;
        for (int t = 0; t < 20000 && !dn; t++) begin
            @(negedge i_mclk);
            wr = o_wready;
            dn = (o_done === 1'b1);
            sa = sa | (o_sel_active === 1'b1);
            bz = bz | (o_busy === 1'b1);
            if (o_rvalid === 1'b1) rq.push_back(o_rdata);
            @(posedge i_mclk);
            #1;
            if (wr === 1'b1) begin
                k++;
                i_wdata = (k < wq.size()) ? wq[k] : WORD_ZERO;
            end
        end
        i_wvalid = 1'b0;
        `CHK("frame end", 1'b1, dn)
        `CHK("select seen", 1'b1, sa)
        `CHK("host busy", 1'b1, bz)
    endtask
    task automatic chk_ev(input logic w, input hsr_addr_t a, input hsr_word_t d);
        logic [31:0] e;
        e = (ev.size() > 0) ? ev.pop_front() : 'x;
        `CHK("access", {w, a, d}, e)
    endtask
    // An all-zero write is read the same in either bit order, so it safely flushes mode changes.
    task automatic junk();
        wq = '{WORD_ZERO};
        frame(1'b0, ADDR_ZERO, CNT_ONE);
        ev = {};
    endtask
    task automatic t_write_burst();
        wq = '{16'hA5C3, 16'h0F01, 16'h8000};
        frame(1'b0, 15'h0005, 16'h0003);
        `CHK("instr", {1'b0, 15'h0005}, instr)
        `CHK("clocks", 64, nb)
        for (int i = 0; i < 3; i++) chk_ev(1'b1, 15'(5 + i), wq[i]);
        wq = '{16'h1234, 16'h5678};
        frame(1'b0, 15'h7FFF, 16'h0002);
        chk_ev(1'b1, 15'h7FFF, 16'h1234);
        chk_ev(1'b1, 15'h0000, 16'h5678);
    endtask
    task automatic t_read_burst();
        frame(1'b1, 15'h0005, 16'h0003);
        `CHK("instr", {1'b1, 15'h0005}, instr)
        `CHK("clocks", 80, nb)
        `CHK("words", 3, rq.size())
        `CHK("rdata0", 16'hA5C3, rq[0])
        `CHK("rdata1", 16'h0F01, rq[1])
        `CHK("rdata2", 16'h8000, rq[2])
        for (int i = 0; i < 3; i++) chk_ev(1'b0, 15'(5 + i), wq[0] ^ wq[0] | (i == 0 ? 16'hA5C3 : i == 1 ? 16'h0F01 : 16'h8000));
    endtask
    task automatic t_read_single();
        for (int c = 0; c < 2; c++) begin
            frame(1'b1, 15'h4006, 16'(c));
            `CHK("instr", {1'b1, 15'h4006}, instr)
            `CHK("clocks", 48, nb)
            `CHK("words", 1, rq.size())
            `CHK("rdata", 16'h0F01, rq[0])
            chk_ev(1'b0, 15'h4006, 16'h0F01);
        end
    endtask
    task automatic t_decrement();
        i_addr_dec = 1'b1;
        junk();
        wq = '{16'hC001, 16'hC002};
        frame(1'b0, 15'h000A, 16'h0002);
        chk_ev(1'b1, 15'h000A, 16'hC001);
        chk_ev(1'b1, 15'h0009, 16'hC002);
        i_addr_dec = 1'b0;
    endtask
    task automatic t_lsb_three();
        hsr_word_t e;
        e = {<<{16'h8014}};
        i_lsb_first = 1'b1;
        i_three_wire = 1'b1;
        junk();
        wq = '{16'h8001, 16'h3C5A};
        frame(1'b0, 15'h0014, 16'h0002);
        frame(1'b1, 15'h0014, 16'h0002);
        `CHK("instr lsb", e, instr)
        `CHK("clocks", 64, nb)
        `CHK("rdata0", 16'h8001, rq[0])
        `CHK("rdata1", 16'h3C5A, rq[1])
    endtask
    initial begin
        i_nrst = 1'b0;
        i_three_wire = 1'b0;
        i_lsb_first = 1'b0;
        i_addr_dec = 1'b0;
        i_start = 1'b0;
        i_rw = 1'b0;
        i_wvalid = 1'b0;
        i_addr = ADDR_ZERO;
        i_count = WORD_ZERO;
        i_wdata = WORD_ZERO;
        repeat (20) @(posedge i_mclk);
        #1 i_nrst = 1'b1;
        junk();
        t_write_burst();
        t_read_burst();
        t_read_single();
        t_decrement();
        t_lsb_three();
        wrap_up();
    end
    initial begin
        #3000000;
        err_total++;
        wrap_up();
    end
endmodule
